// ---- psc_map.vh ----
`ifndef PSC_MAP_VH
`define PSC_MAP_VH

// ============================================================
// register indices (byte address is four times the low byte)
`define PSC_IDX_WAKE_PWR      32'h50000010
`define PSC_IDX_SYS_CTRL      32'h50000012
`define PSC_IDX_SYS_STAT      32'h50000014

// ============================================================
// wake_power_control fields
`define PSC_WP_HARD_RST_BIT   0
`define PSC_WP_TIM_PD_BIT     1
`define PSC_WP_RAD_PD_BIT     2
`define PSC_WP_DIV_LSB        4
`define PSC_WP_DIV_MSB        5
`define PSC_WP_DIAG_MAP_BIT   6
`define PSC_WP_RESET          7'h06

// ============================================================
// system_control fields
`define PSC_SC_RSV5_BIT       5
`define PSC_SC_OTP_RST_BIT    6
`define PSC_SC_DBG_LSB        7
`define PSC_SC_DBG_MSB        8
`define PSC_SC_TMO_DIS_BIT    10
`define PSC_SC_SW_RST_BIT     15
`define PSC_SC_RESET          16'h0020
`define PSC_SC_WMASK          16'h05e0

// ============================================================
// debug pin selection codes
`define PSC_DBG_NONE          2'h0
`define PSC_DBG_DIO_P5        2'h1
`define PSC_DBG_DIO_P1        2'h2
`define PSC_DBG_DIO_P10       2'h3

// ============================================================
// timing: start-up timeout of the power state machine
`define PSC_TIMEOUT_MS        2
`define PSC_CLK_MHZ           100
`define PSC_TIMEOUT_CYC       (`PSC_TIMEOUT_MS * 1000 * `PSC_CLK_MHZ)

`endif

// ---- psc_power_sys_ctrl.v ----
// Behaviour
// - diag map bit forces pin 2 to reference-on, pin 1 to wake indicator
// - two-bit divider slows bus clock enable while OTP mirroring runs
// - radio digital powerdown request follows its bit, reset value one
// - timer domain powerdown request follows its bit, reset value one
// - hard-reset-after-wake bit turns a wake event into a device reset
// - writing one to bit 15 resets all but system control and trim
// - power state machine times out after 2 ms unless bit 10 is set
// - debug select: 0 none, else clock on pin 2, data on 5, 1 or 10
// - with no debugger selected and diag map off, debug pins serve as general purpose I/O
// - system control bit 6 drives the OTP controller reset request
// - status register reports whether a debugger is attached
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "psc_map.vh"

module psc_power_sys_ctrl #(
    parameter NPIN           = 12,
    parameter CNT_W          = 18,
    parameter TIMEOUT_CYCLES = `PSC_TIMEOUT_CYC
) (
    // clock and reset
    input  wire              CLK,
    input  wire              RESET,
    // ahb-lite slave
    input  wire              HSEL,
    input  wire [31:0]       HADDR,
    input  wire [1:0]        HTRANS,
    input  wire              HWRITE,
    input  wire [2:0]        HSIZE,
    input  wire [31:0]       HWDATA,
    input  wire              HREADY,
    output wire              HREADYOUT,
    output wire              HRESP,
    output reg  [31:0]       HRDATA,
    // port pins
    input  wire [NPIN-1:0]   PIN_IN,
    output reg  [NPIN-1:0]   PIN_OUT,
    output reg  [NPIN-1:0]   PIN_OE,
    // general purpose i/o block
    input  wire [NPIN-1:0]   GPIO_OUT,
    input  wire [NPIN-1:0]   GPIO_OE,
    output wire [NPIN-1:0]   GPIO_IN,
    // debug port
    output wire              DBG_CLK_IN,
    output wire              DBG_DIO_IN,
    input  wire              DBG_DIO_OUT,
    input  wire              DBG_DIO_OE,
    input  wire              DBG_ATTACHED,
    // wake diagnostics sources
    input  wire              REF_ON_IND,
    input  wire              WAKE_IND,
    // power domains and reset tree
    input  wire              TIM_IS_UP,
    input  wire              TIM_IS_DOWN,
    input  wire              RAD_IS_UP,
    input  wire              RAD_IS_DOWN,
    input  wire              WAKE_EVENT,
    output wire              RADIO_PD_REQ,
    output wire              TIMER_PD_REQ,
    output reg               DEVICE_RESET_REQ,
    output wire              OTP_CTRL_RST_REQ,
    // otp mirroring clock enable
    input  wire              OTP_MIRROR_ACTIVE,
    output reg               HCLK_EN,
    // power state machine timeout
    input  wire              PSM_WAITING,
    output reg               PSM_TIMEOUT
);

    localparam NSYNC = NPIN + 5;

    // ========================================================
    // input synchronisers
    // three stages; the filtered value moves once stages two
    // and three agree, so a single-cycle glitch never counts
    wire [NSYNC-1:0] async_in;
    reg  [NSYNC-1:0] sync1_r;
    reg  [NSYNC-1:0] sync2_r;
    reg  [NSYNC-1:0] sync3_r;
    reg  [NSYNC-1:0] filt_r;

    assign async_in = {DBG_ATTACHED, TIM_IS_UP, TIM_IS_DOWN,
                       RAD_IS_UP, RAD_IS_DOWN, PIN_IN};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1)
        begin : g_sync
            // per-bit synchroniser and agreement filter
            always @(posedge CLK)
            begin
                if (RESET)
                begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                    sync3_r[gi] <= 1'b0;
                    filt_r[gi]  <= 1'b0;
                end
                else
                begin
                    sync1_r[gi] <= async_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                    if (sync2_r[gi] == sync3_r[gi])
                        filt_r[gi] <= sync3_r[gi];
                end
            end
        end
    endgenerate

    wire [NPIN-1:0] pin_s = filt_r[NPIN-1:0];
    wire [3:0]      pd_stat_s = filt_r[NPIN+3:NPIN];
    wire            dbg_att_s = filt_r[NPIN+4];

    // ========================================================
    // ahb-lite address phase capture
    // no wait states: every access finishes in one data phase
    reg        dp_wr_r;
    reg        dp_valid_r;
    reg  [7:0] dp_idx_r;
    wire       ap_valid = HSEL & HTRANS[1] & HREADY;
    wire [7:0] ap_idx = HADDR[9:2];
    // only the low byte of each index is decoded; upper bits alias
    localparam [31:0] IDX_WP = `PSC_IDX_WAKE_PWR;
    localparam [31:0] IDX_SC = `PSC_IDX_SYS_CTRL;
    localparam [31:0] IDX_ST = `PSC_IDX_SYS_STAT;
    wire [7:0] idx_wp = IDX_WP[7:0];
    wire [7:0] idx_sc = IDX_SC[7:0];
    wire [7:0] idx_st = IDX_ST[7:0];

    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    always @(posedge CLK)
    begin
        if (RESET)
        begin
            dp_valid_r <= 1'b0;
            dp_wr_r    <= 1'b0;
            dp_idx_r   <= 8'h00;
        end
        else if (HREADY)
        begin
            dp_valid_r <= ap_valid;
            dp_wr_r    <= HWRITE;
            dp_idx_r   <= ap_idx;
        end
    end

    wire wr_wp = dp_valid_r & dp_wr_r & (dp_idx_r == idx_wp);
    wire wr_sc = dp_valid_r & dp_wr_r & (dp_idx_r == idx_sc);

    // ========================================================
    // registers
    reg  [6:0]  wp_r;
    reg  [6:0]  wp_nxt;
    reg  [15:0] sc_r;
    reg  [15:0] sc_nxt;
    reg         sw_rst_r;
    wire        sw_rst_hit = wr_sc & HWDATA[`PSC_SC_SW_RST_BIT];

    // next values; writes of reserved bit 3 are dropped
    always @*
    begin
        wp_nxt = wp_r;
        sc_nxt = sc_r;
        if (wr_wp)
            wp_nxt = HWDATA[6:0] & 7'h77;
        if (wr_sc)
            sc_nxt = HWDATA[15:0] & `PSC_SC_WMASK;
    end

    // software reset clears wake_power_control but spares
    // system_control, which only the hard reset clears
    always @(posedge CLK)
    begin
        wp_r <= (RESET | sw_rst_r) ? `PSC_WP_RESET : wp_nxt;
        sc_r <= RESET ? `PSC_SC_RESET : sc_nxt;
    end

    // ========================================================
    // read data, forwarded from next values so a read right
    // after a write returns the new contents
    always @(posedge CLK)
    begin
        if (RESET)
            HRDATA <= 32'h00000000;
        else if (HREADY & ap_valid & ~HWRITE)
        begin
            if (ap_idx == idx_wp)
                HRDATA <= {25'h0000000, wp_nxt};
            else if (ap_idx == idx_sc)
                HRDATA <= {16'h0000, sc_nxt};
            else if (ap_idx == idx_st)
                HRDATA <= {27'h0000000, dbg_att_s, pd_stat_s};
            else
                HRDATA <= 32'h00000000;
        end
    end

    // ========================================================
    // reset requests
    // the outside reset tree answers by asserting RESET
    wire wake_rst = WAKE_EVENT & wp_r[`PSC_WP_HARD_RST_BIT];

    always @(posedge CLK)
    begin
        sw_rst_r         <= ~RESET & sw_rst_hit;
        DEVICE_RESET_REQ <= ~RESET & (sw_rst_hit | wake_rst);
    end

    assign RADIO_PD_REQ     = wp_r[`PSC_WP_RAD_PD_BIT];
    assign TIMER_PD_REQ     = wp_r[`PSC_WP_TIM_PD_BIT];
    assign OTP_CTRL_RST_REQ = sc_r[`PSC_SC_OTP_RST_BIT];

    // ========================================================
    // bus clock enable during otp mirroring
    // field value n divides by two to the n; outside mirroring
    // the enable stays high so the bus runs at full rate
    reg  [2:0] div_cnt_r;
    wire [1:0] div_sel = wp_r[`PSC_WP_DIV_MSB:`PSC_WP_DIV_LSB];
    reg  [2:0] div_last;

    always @*
    begin
        case (div_sel)
            2'h0:    div_last = 3'h0;
            2'h1:    div_last = 3'h1;
            2'h2:    div_last = 3'h3;
            default: div_last = 3'h7;
        endcase
    end

    always @(posedge CLK)
    begin
        if (RESET | ~OTP_MIRROR_ACTIVE | (div_cnt_r >= div_last))
        begin
            div_cnt_r <= 3'h0;
            HCLK_EN   <= 1'b1;
        end
        else
        begin
            div_cnt_r <= div_cnt_r + 3'h1;
            HCLK_EN   <= 1'b0;
        end
    end

    // ========================================================
    // power state machine start-up timeout
    // one pulse per wait; the counter holds after firing so a
    // long wait never produces a second pulse
    reg  [CNT_W-1:0] tmo_cnt_r;
    localparam [31:0] TMO_LAST_W = TIMEOUT_CYCLES - 1;
    wire [CNT_W-1:0] tmo_last = TMO_LAST_W[CNT_W-1:0];
    wire             tmo_dis = sc_r[`PSC_SC_TMO_DIS_BIT];

    always @(posedge CLK)
    begin
        if (RESET | ~PSM_WAITING | tmo_dis)
        begin
            tmo_cnt_r   <= {CNT_W{1'b0}};
            PSM_TIMEOUT <= 1'b0;
        end
        else if (tmo_cnt_r == tmo_last)
        begin
            tmo_cnt_r   <= tmo_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
            PSM_TIMEOUT <= 1'b1;
        end
        else
        begin
            if (tmo_cnt_r < tmo_last)
                tmo_cnt_r <= tmo_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
            PSM_TIMEOUT <= 1'b0;
        end
    end

    // ========================================================
    // pin multiplexer
    // diag mapping beats the debugger on the shared clock pin;
    // software must detach the debugger first
    wire [1:0] dbg_sel = sc_r[`PSC_SC_DBG_MSB:`PSC_SC_DBG_LSB];
    wire       diag_on = wp_r[`PSC_WP_DIAG_MAP_BIT];
    reg  [3:0] dio_pin;
    reg  [NPIN-1:0] out_nxt;
    reg  [NPIN-1:0] oe_nxt;

    // data pin number for the selected debug mapping
    always @*
    begin
        case (dbg_sel)
            `PSC_DBG_DIO_P5:  dio_pin = 4'h5;
            `PSC_DBG_DIO_P1:  dio_pin = 4'h1;
            `PSC_DBG_DIO_P10: dio_pin = 4'ha;
            default:          dio_pin = 4'h0;
        endcase
    end

    always @*
    begin
        out_nxt = GPIO_OUT;
        oe_nxt  = GPIO_OE;
        if (dbg_sel != `PSC_DBG_NONE)
        begin
            oe_nxt[2]        = 1'b0;
            out_nxt[2]       = 1'b0;
            out_nxt[dio_pin] = DBG_DIO_OUT;
            oe_nxt[dio_pin]  = DBG_DIO_OE;
        end
        if (diag_on)
        begin
            out_nxt[2] = REF_ON_IND;
            oe_nxt[2]  = 1'b1;
            out_nxt[1] = WAKE_IND;
            oe_nxt[1]  = 1'b1;
        end
    end

    always @(posedge CLK)
    begin
        PIN_OUT <= RESET ? {NPIN{1'b0}} : out_nxt;
        PIN_OE  <= RESET ? {NPIN{1'b0}} : oe_nxt;
    end

    // inputs toward gpio and debugger; gpio sees every pin,
    // debug pins included, even while a debugger owns them
    wire dbg_on = (dbg_sel != `PSC_DBG_NONE);
    assign DBG_CLK_IN = dbg_on & pin_s[2];
    assign DBG_DIO_IN = dbg_on & pin_s[dio_pin];
    assign GPIO_IN    = pin_s;

endmodule // psc_power_sys_ctrl

// ---- psc_props.sv ----
`timescale 1ns/1ps
// ============================================================
// port checks of the control block
module psc_props #(
    parameter NPIN = 12
) (
    // clock, reset and bus
    input wire            CLK,
    input wire            RESET,
    input wire            HSEL,
    input wire [31:0]     HADDR,
    input wire [1:0]      HTRANS,
    input wire            HWRITE,
    input wire            HREADY,
    input wire [31:0]     HWDATA,
    input wire [31:0]     HRDATA,
    // control outputs, and the PSM_WAITING input
    input wire [NPIN-1:0] PIN_OE,
    input wire            RADIO_PD_REQ,
    input wire            TIMER_PD_REQ,
    input wire            OTP_CTRL_RST_REQ,
    input wire            DEVICE_RESET_REQ,
    input wire            PSM_WAITING,
    input wire            PSM_TIMEOUT
);
    // taken address phases; only HADDR[9:2] is decoded, upper bits alias
    wire take  = HSEL & HTRANS[1] & HREADY;
    wire wp_wr = take & HWRITE & (HADDR[9:2] == 8'h10);
    wire sc_wr = take & HWRITE & (HADDR[9:2] == 8'h12);
    wire sc_rd = take & ~HWRITE & (HADDR[9:2] == 8'h12);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    property p_rad_pd;
        wp_wr ##1 1'b1 |=> RADIO_PD_REQ == $past(HWDATA[2]);
    endproperty
    a_rad_pd: assert property (p_rad_pd)
        else $error("radio powerdown request wrong");
    property p_tim_pd;
        wp_wr ##1 1'b1 |=> TIMER_PD_REQ == $past(HWDATA[1]);
    endproperty
    a_tim_pd: assert property (p_tim_pd)
        else $error("timer powerdown request wrong");
    property p_otp_rst;
        sc_wr ##1 1'b1 |=> OTP_CTRL_RST_REQ == $past(HWDATA[6]);
    endproperty
    a_otp_rst: assert property (p_otp_rst)
        else $error("otp controller reset request wrong");
    property p_rst_vals;
        $fell(RESET) |-> RADIO_PD_REQ && TIMER_PD_REQ && !OTP_CTRL_RST_REQ;
    endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("request levels wrong after reset");
    property p_sw_rst;
        sc_wr ##1 HWDATA[15] |=> ##[0:1] DEVICE_RESET_REQ;
    endproperty
    a_sw_rst: assert property (p_sw_rst)
        else $error("software reset gave no device reset");
    property p_sw_rd0;
        sc_rd |=> HRDATA[15] == 1'b0;
    endproperty
    a_sw_rd0: assert property (p_sw_rd0)
        else $error("software reset bit read as one");
    property p_diag_oe;
        wp_wr ##1 HWDATA[6] |=> ##1 PIN_OE[2] && PIN_OE[1];
    endproperty
    a_diag_oe: assert property (p_diag_oe)
        else $error("diagnostic pins not driven");
    property p_to_early;
        $rose(PSM_WAITING) |=> !PSM_TIMEOUT [*8];
    endproperty
    a_to_early: assert property (p_to_early)
        else $error("start-up timeout came too early");
endmodule // psc_props

// ---- testbench.sv ----
`timescale 1ns/1ps
`include "psc_map.vh"
module testbench;
    // ============================================================
    // design signals, all inputs valued at time zero
    logic CLK = 1'b0, RESET = 1'b1, HSEL = 1'b0, HWRITE = 1'b0;
    logic DBG_DIO_OUT = 1'b0, DBG_DIO_OE = 1'b0, DBG_ATTACHED = 1'b0;
    logic REF_ON_IND = 1'b0, WAKE_IND = 1'b0, TIM_IS_UP = 1'b0;
    logic TIM_IS_DOWN = 1'b1, RAD_IS_UP = 1'b0, RAD_IS_DOWN = 1'b1;
    logic WAKE_EVENT = 1'b0, OTP_MIRROR_ACTIVE = 1'b0, PSM_WAITING = 1'b0;
    logic [1:0]  HTRANS = 2'h0;
    logic [2:0]  HSIZE = 3'h2;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0;
    logic [11:0] PIN_IN = 12'h0, GPIO_OUT = 12'h0, GPIO_OE = 12'h0;
    wire         HREADY, HREADYOUT, HRESP, DBG_CLK_IN, DBG_DIO_IN;
    wire         RADIO_PD_REQ, TIMER_PD_REQ, DEVICE_RESET_REQ, HCLK_EN;
    wire         OTP_CTRL_RST_REQ, PSM_TIMEOUT;
    wire [31:0]  HRDATA;
    wire [11:0]  PIN_OUT, PIN_OE, GPIO_IN;
    int          err_count = 0, cmp_count = 0, n, i, p, s, c;
    logic [31:0] seed = 32'h29, rd, v, wp_m, sc_m;
    localparam logic [31:0] A_WP = `PSC_IDX_WAKE_PWR << 2;
    localparam logic [31:0] A_SC = `PSC_IDX_SYS_CTRL << 2;
    localparam logic [31:0] A_ST = `PSC_IDX_SYS_STAT << 2;
    localparam int TO = 20;
    // the one slave's ready is the bus ready
    assign HREADY = HREADYOUT;
    psc_power_sys_ctrl #(.TIMEOUT_CYCLES(TO)) dut (.*);
    initial forever #5 CLK = ~CLK;
    // ============================================================
    // helpers
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // a slave that never answers would hang the run, so the wait is bounded
    task wait_rdy();
        n = 0;
        do @(posedge CLK); while (HREADY !== 1'b1 && ++n < 64);
        if (HREADY !== 1'b1)
        begin
            err_count++;
            give_verdict();
        end
    endtask
    // one single transfer; read data taken at the data-phase edge
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= a;
        HWRITE <= w;
        wait_rdy();
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        wait_rdy();
        rd = HRDATA;
    endtask
    // ============================================================
    // main sequence
    initial
    begin
        repeat (16) @(posedge CLK);
        RESET <= 1'b0;
        bus(1'b0, A_WP, 32'h0);
        check(rd, 32'h6);
        bus(1'b0, A_SC, 32'h0);
        check(rd, `PSC_SC_RESET);
        // every debug code and divider, diag map on and off
        for (i = 0; i < 8; i++)
        begin
            {DBG_ATTACHED, TIM_IS_UP, TIM_IS_DOWN, RAD_IS_UP} <= rnd();
            {RAD_IS_DOWN, REF_ON_IND, WAKE_IND, DBG_DIO_OUT} <= rnd();
            {DBG_DIO_OE, PIN_IN, GPIO_OUT, GPIO_OE} <= rnd();
            v = (rnd() & 32'hf) | (i << 4);
            wp_m = v & 32'h77;
            bus(1'b1, A_WP, v);
            v = (rnd() & 32'h7e7f) | ((i & 3) << 7);
            sc_m = v & `PSC_SC_WMASK;
            bus(1'b1, A_SC, v);
            bus(1'b0, A_WP, rnd());
            check(rd, wp_m);
            bus(1'b0, A_SC, rnd());
            check(rd, sc_m);
            bus(1'b0, A_ST, rnd());
            check(rd, {DBG_ATTACHED, TIM_IS_UP, TIM_IS_DOWN, RAD_IS_UP,
                       RAD_IS_DOWN});
            check({RADIO_PD_REQ, TIMER_PD_REQ}, wp_m[2:1]);
            check(OTP_CTRL_RST_REQ, sc_m[6]);
            if (wp_m[6])
                check({PIN_OUT[2:1], PIN_OE[2:1]},
                      {REF_ON_IND, WAKE_IND, 2'h3});
            p = (sc_m[8:7] == 2'h1) ? 5 : (sc_m[8:7] == 2'h2) ? 1 : 10;
            if (sc_m[8:7] != 2'h0 && !(wp_m[6] && p == 1))
                check({PIN_OUT[p], PIN_OE[p]}, {DBG_DIO_OUT, DBG_DIO_OE});
            v = wp_m[6] ? 32'hff9 : 32'hfff;
            if (sc_m[8:7] == 2'h0)
                check({PIN_OUT, PIN_OE} & {v[11:0], v[11:0]},
                      {GPIO_OUT, GPIO_OE} & {v[11:0], v[11:0]});
            check(GPIO_IN, PIN_IN);
            check(DBG_CLK_IN, sc_m[8:7] != 2'h0 && PIN_IN[2]);
            check(DBG_DIO_IN, sc_m[8:7] != 2'h0 && PIN_IN[p]);
            check(HRESP, 1'b0);
            // mirroring: enable high one cycle in each divided period
            OTP_MIRROR_ACTIVE <= 1'b1;
            repeat (3) @(posedge CLK);
            c = 0;
            repeat (32) @(posedge CLK) c += HCLK_EN;
            check(c, 32 >> wp_m[5:4]);
            OTP_MIRROR_ACTIVE <= 1'b0;
            // the debugger is detached before sleeping with diag map on
            if (wp_m[6])
                DBG_ATTACHED <= 1'b0;
            WAKE_EVENT <= 1'b1;
            @(posedge CLK);
            WAKE_EVENT <= 1'b0;
            @(posedge CLK);
            check(DEVICE_RESET_REQ, wp_m[0]);
        end
        // software reset spares system control only
        bus(1'b1, A_SC, sc_m | 32'h8000);
        s = 0;
        repeat (4) @(posedge CLK) s |= DEVICE_RESET_REQ;
        check(s, 1);
        bus(1'b0, A_WP, 32'h0);
        check(rd, 32'h6);
        bus(1'b0, A_SC, 32'h0);
        check(rd, sc_m);
        // unmapped place: ignored writes, zero reads
        bus(1'b1, 32'h4000007c, 32'hffff);
        bus(1'b0, 32'h4000007c, 32'h0);
        check(rd, 32'h0);
        // start-up timeout, then with it disabled
        for (i = 0; i < 2; i++)
        begin
            sc_m = (sc_m & 32'hfbff) | (i << 10);
            bus(1'b1, A_SC, sc_m);
            PSM_WAITING <= 1'b1;
            n = 0;
            do @(posedge CLK); while (PSM_TIMEOUT !== 1'b1 && ++n < 40);
            check(i ? n == 40 : n >= TO - 1 && n <= TO + 2, 1);
            PSM_WAITING <= 1'b0;
            @(posedge CLK);
        end
        give_verdict();
    end
endmodule // testbench
bind psc_power_sys_ctrl psc_props #(.NPIN(NPIN)) u_props (
    .CLK(CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HWDATA(HWDATA),
    .HRDATA(HRDATA), .PIN_OE(PIN_OE), .RADIO_PD_REQ(RADIO_PD_REQ),
    .TIMER_PD_REQ(TIMER_PD_REQ), .OTP_CTRL_RST_REQ(OTP_CTRL_RST_REQ),
    .DEVICE_RESET_REQ(DEVICE_RESET_REQ), .PSM_WAITING(PSM_WAITING),
    .PSM_TIMEOUT(PSM_TIMEOUT));
